// ### dv/iad_rf_model.sv
// register file model standing behind the integer add datapath
`timescale 1ns/100ps
module iad_rf_model
(
   input wire logic sys_clk_in,
   input wire logic [4:0] rd_a_idx_in,
   input wire logic [4:0] rd_b_idx_in,
   input wire iad_pkg::iad_set_type rd_a_set_in,
   input wire iad_pkg::iad_set_type rd_b_set_in,
   input wire logic wr_en_in,
   input wire logic [4:0] wr_idx_in,
   input wire iad_pkg::iad_set_type wr_set_in,
   input wire iad_pkg::iad_word_type wr_data_in,
   output iad_pkg::iad_word_type rd_a_data_out,
   output iad_pkg::iad_word_type rd_b_data_out
);
   import iad_pkg::*;
   iad_word_type mem_r [0:63][0:31];  // every set, every register

   // ***************************************************************
   // storage
   // ***************************************************************
   // distinct start contents so a wrong set or index shows up
   initial
   begin
      for (int s = 0; s < 64; s++)
         for (int i = 0; i < 32; i++)
            mem_r[s][i] = {10'h000, 6'(s), 11'h000, 5'(i)};
   end

   // write lands at the end of the strobe cycle
   always @(posedge sys_clk_in)
   begin
      if (wr_en_in)
         mem_r[wr_set_in][wr_idx_in] <= wr_data_in;
   end

   // reads answer in the same cycle
   assign rd_a_data_out = mem_r[rd_a_set_in][rd_a_idx_in];
   assign rd_b_data_out = mem_r[rd_b_set_in][rd_b_idx_in];
endmodule : iad_rf_model

// ### dv/integer_add_datapath_test.sv
// self-checking bench of the integer add datapath
`timescale 1ns/100ps
`define CHECK(name, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
         begin \
            error_cnt++; \
            $display("Error %s expected %h seen %h", name, exp, got); \
         end \
   end
module integer_add_datapath_test;
   import iad_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic pc_load_in = 1'b0;
   logic prev_a_sel_in = 1'b0;
   logic prev_b_sel_in = 1'b0;
   logic [4:0] fault_in = 5'h00;  // super, fast, double, exec, region
   iad_word_type instr_word_in = 32'h0000_0000;
   iad_word_type pc_load_addr_in = 32'h0000_0000;
   iad_set_type cur_set_in = 6'h00;
   iad_set_type prev_set_in = 6'h00;
   iad_word_type rd_a_data, rd_b_data, wr_data, exc_pc, fetch_pc, exp_pc;
   logic [4:0] rd_a_idx, rd_b_idx, wr_idx;
   iad_set_type rd_a_set, rd_b_set, wr_set;
   logic wr_en, other_op, exc_valid;
   iad_cause_type exc_cause;
   int error_cnt = 0;
   int tests_run = 0;

   // ***************************************************************
   // clock, design and partner
   // ***************************************************************
   initial
   begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   iad_datapath dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
      .fetch_super_only_in(fault_in[0]), .fetch_fast_miss_in(fault_in[1]),
      .fetch_double_miss_in(fault_in[2]), .fetch_exec_viol_in(fault_in[3]),
      .fetch_region_viol_in(fault_in[4]), .cur_set_in(cur_set_in),
      .prev_set_in(prev_set_in), .prev_a_sel_in(prev_a_sel_in),
      .prev_b_sel_in(prev_b_sel_in), .rf_rd_a_data_in(rd_a_data),
      .rf_rd_b_data_in(rd_b_data), .pc_load_in(pc_load_in),
      .pc_load_addr_in(pc_load_addr_in), .rf_rd_a_idx_out(rd_a_idx),
      .rf_rd_b_idx_out(rd_b_idx), .rf_rd_a_set_out(rd_a_set),
      .rf_rd_b_set_out(rd_b_set), .rf_wr_en_out(wr_en), .rf_wr_idx_out(wr_idx),
      .rf_wr_set_out(wr_set), .rf_wr_data_out(wr_data), .other_op_out(other_op),
      .exc_valid_out(exc_valid), .exc_cause_out(exc_cause), .exc_pc_out(exc_pc),
      .fetch_pc_out(fetch_pc));

   iad_rf_model rf (.sys_clk_in(sys_clk_in), .rd_a_idx_in(rd_a_idx),
      .rd_b_idx_in(rd_b_idx), .rd_a_set_in(rd_a_set), .rd_b_set_in(rd_b_set),
      .wr_en_in(wr_en), .wr_idx_in(wr_idx), .wr_set_in(wr_set),
      .wr_data_in(wr_data), .rd_a_data_out(rd_a_data), .rd_b_data_out(rd_b_data));

   // ***************************************************************
   // word builders and drivers
   // ***************************************************************
   function automatic iad_word_type rword(input logic [4:0] a, b, c, input logic [5:0] x);
      return {a, b, c, x, 5'h00, 6'h3a};
   endfunction : rword

   function automatic iad_word_type iword(input logic [4:0] a, b, input logic [15:0] m,
                                          input logic [5:0] op);
      return {a, b, m, op};
   endfunction : iword

   // one word for one cycle, results visible on return
   task automatic offer(input iad_word_type w, input logic [4:0] f);
      @(posedge sys_clk_in);
      #1;
      instr_word_in = w;
      fault_in = f;
      instr_valid_in = 1'b1;
      @(posedge sys_clk_in);
      #1;
      instr_valid_in = 1'b0;
      fault_in = 5'h00;
   endtask : offer

   // one add word, operands from the model, write checked
   task automatic add_case(input iad_word_type w, input logic imm);
      iad_set_type sa, sb;
      iad_word_type ea, eb, sum;
      logic [4:0] dst;
      sa = prev_a_sel_in ? prev_set_in : cur_set_in;
      sb = prev_b_sel_in ? prev_set_in : cur_set_in;
      ea = rf.mem_r[sa][w[31:27]];
      eb = imm ? {{16{w[21]}}, w[21:6]} : rf.mem_r[sb][w[26:22]];
      sum = ea + eb;
      dst = imm ? w[26:22] : w[21:17];
      offer(w, 5'h00);
      exp_pc = exp_pc + 32'h0000_0004;
      `CHECK("rd_a_idx", w[31:27], rd_a_idx)
      `CHECK("rd_b_idx", w[26:22], rd_b_idx)
      `CHECK("rd_a_set", sa, rd_a_set)
      `CHECK("rd_b_set", sb, rd_b_set)
      `CHECK("wr_en", 1'b1, wr_en)
      `CHECK("wr_idx", dst, wr_idx)
      `CHECK("wr_set", cur_set_in, wr_set)
      `CHECK("wr_data", sum, wr_data)
      `CHECK("fetch_pc", exp_pc, fetch_pc)
      @(posedge sys_clk_in);
      #1;
      `CHECK("wr_en_end", 1'b0, wr_en)
   endtask : add_case

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_add();
      cur_set_in = 6'h05;
      add_case(rword(5'h01, 5'h02, 5'h03, 6'h31), 1'b0);
      add_case(iword(5'h07, 5'h08, 16'hff9c, 6'h04), 1'b1);
      cur_set_in = 6'h00;
      add_case(iword(5'h00, 5'h04, 16'hffff, 6'h04), 1'b1);
      add_case(iword(5'h00, 5'h05, 16'h0001, 6'h04), 1'b1);
      add_case(rword(5'h04, 5'h05, 5'h06, 6'h31), 1'b0);
      `CHECK("wrap_zero", 32'h0000_0000, wr_data)
      `CHECK("no_ovf_exc", 1'b0, exc_valid)
      $display("test add done");
   endtask : t_add

   task automatic t_prev();
      cur_set_in = 6'h05;
      prev_set_in = 6'h09;
      prev_a_sel_in = 1'b1;
      add_case(rword(5'h0a, 5'h0b, 5'h0c, 6'h31), 1'b0);
      prev_a_sel_in = 1'b0;
      prev_b_sel_in = 1'b1;
      add_case(rword(5'h0d, 5'h0e, 5'h0f, 6'h31), 1'b0);
      prev_b_sel_in = 1'b0;
      $display("test prev set done");
   endtask : t_prev

   task automatic t_other();
      offer(rword(5'h01, 5'h02, 5'h03, 6'h39), 5'h00);
      exp_pc = exp_pc + 32'h0000_0004;
      `CHECK("other_r", 1'b1, other_op)
      `CHECK("wr_en_r", 1'b0, wr_en)
      offer(iword(5'h01, 5'h02, 16'h1234, 6'h14), 5'h00);
      exp_pc = exp_pc + 32'h0000_0004;
      `CHECK("other_i", 1'b1, other_op)
      `CHECK("wr_en_i", 1'b0, wr_en)
      `CHECK("fetch_pc", exp_pc, fetch_pc)
      $display("test other op done");
   endtask : t_other

   task automatic t_fault();
      for (int i = 0; i < 6; i++)
      begin
         offer(rword(5'h01, 5'h02, 5'h03, 6'h31), i < 5 ? 5'(1 << i) : 5'h1f);
         `CHECK("exc_valid", 1'b1, exc_valid)
         `CHECK("exc_cause", 3'(i < 5 ? i + 1 : 1), exc_cause)
         `CHECK("exc_pc", exp_pc, exc_pc)
         `CHECK("wr_en", 1'b0, wr_en)
         `CHECK("fetch_pc", exp_pc, fetch_pc)
      end
      @(posedge sys_clk_in);
      #1;
      `CHECK("exc_end", 1'b0, exc_valid)
      $display("test fault done");
   endtask : t_fault

   task automatic t_pc();
      @(posedge sys_clk_in);
      #1;
      pc_load_in = 1'b1;
      pc_load_addr_in = 32'h0000_0100;
      instr_word_in = iword(5'h00, 5'h07, 16'h0001, 6'h04);
      instr_valid_in = 1'b1;
      @(posedge sys_clk_in);
      #1;
      pc_load_in = 1'b0;
      instr_valid_in = 1'b0;
      exp_pc = 32'h0000_0100;
      `CHECK("pc_load", exp_pc, fetch_pc)
      @(posedge sys_clk_in);
      add_case(iword(5'h00, 5'h08, 16'h7fff, 6'h04), 1'b1);
      $display("test pc done");
   endtask : t_pc

   // ***************************************************************
   // sequence and verdict
   // ***************************************************************
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   initial
   begin
      exp_pc = 32'h0000_0000;
      repeat (2) @(posedge sys_clk_in);
      #1;
      rst_n_in = 1'b1;
      `CHECK("rst_wr_en", 1'b0, wr_en)
      `CHECK("rst_wr_data", 32'h0000_0000, wr_data)
      `CHECK("rst_exc_valid", 1'b0, exc_valid)
      `CHECK("rst_cause", IAD_CAUSE_NONE, exc_cause)
      `CHECK("rst_exc_pc", 32'h0000_0000, exc_pc)
      `CHECK("rst_other", 1'b0, other_op)
      `CHECK("rst_pc", 32'h0000_0000, fetch_pc)
      t_add();
      t_prev();
      t_other();
      t_fault();
      t_pc();
      give_verdict();
   end

   // watchdog cuts a hang short
   initial
   begin
      #20000;
      error_cnt++;
      give_verdict();
   end
endmodule : integer_add_datapath_test

// ### rtl/iad_add_if.sv
// operand and sum bundle between datapath and adder
`timescale 1ns/100ps
interface iad_add_if;
   logic [31:0] op_a;   // first addend
   logic [31:0] op_b;   // second addend
   logic [31:0] sum;    // wrapped sum

   // side that supplies operands
   modport user (output op_a, output op_b, input sum);
   // side that adds
   modport unit (input op_a, input op_b, output sum);
endinterface : iad_add_if

// ### rtl/iad_adder.sv
// 32-bit wrapping adder shared by both add forms
`timescale 1ns/100ps
module iad_adder
(
   iad_add_if.unit add_port   // operands in, sum out
);
   // ***************************************************************
   // adder
   // ***************************************************************
   // one result serves signed and unsigned use; carry is dropped
   logic [32:0] full_sum;   // sum with carry bit
   assign full_sum = {1'b0, add_port.op_a} + {1'b0, add_port.op_b};  // see RULE_01
   assign add_port.sum = full_sum[31:0];  // see RULE_10
endmodule : iad_adder

// ### rtl/iad_datapath.sv
// integer add datapath between decode and register file
`timescale 1ns/100ps
`include "iad_regs.svh"
module iad_datapath
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic instr_valid_in,
   input wire iad_pkg::iad_word_type instr_word_in,
   input wire logic fetch_super_only_in,
   input wire logic fetch_fast_miss_in,
   input wire logic fetch_double_miss_in,
   input wire logic fetch_exec_viol_in,
   input wire logic fetch_region_viol_in,
   input wire iad_pkg::iad_set_type cur_set_in,
   input wire iad_pkg::iad_set_type prev_set_in,
   input wire logic prev_a_sel_in,
   input wire logic prev_b_sel_in,
   input wire iad_pkg::iad_word_type rf_rd_a_data_in,
   input wire iad_pkg::iad_word_type rf_rd_b_data_in,
   input wire logic pc_load_in,
   input wire iad_pkg::iad_word_type pc_load_addr_in,
   output logic [4:0] rf_rd_a_idx_out,
   output logic [4:0] rf_rd_b_idx_out,
   output iad_pkg::iad_set_type rf_rd_a_set_out,
   output iad_pkg::iad_set_type rf_rd_b_set_out,
   output logic rf_wr_en_out,
   output logic [4:0] rf_wr_idx_out,
   output iad_pkg::iad_set_type rf_wr_set_out,
   output iad_pkg::iad_word_type rf_wr_data_out,
   output logic other_op_out,
   output logic exc_valid_out,
   output iad_pkg::iad_cause_type exc_cause_out,
   output iad_pkg::iad_word_type exc_pc_out,
   output iad_pkg::iad_word_type fetch_pc_out
);
   import iad_pkg::*;

   // ***************************************************************
   // field extraction
   // ***************************************************************
   logic [5:0] primary_opcode_field;    // low opcode bits
   logic [5:0] extended_opcode_field;   // r-type function code
   logic [15:0] sixteen_bit_immediate;  // i-type immediate
   iad_idx_type source_reg_a;           // field A
   iad_idx_type source_reg_b;           // field B
   iad_idx_type dest_reg_c;             // field C

   // bit zero of the word is its lsb
   assign primary_opcode_field = instr_word_in[`IAD_OP_MSB:`IAD_OP_LSB];  // see RULE_08
   assign extended_opcode_field = instr_word_in[`IAD_OPX_MSB:`IAD_OPX_LSB];  // see RULE_02
   assign sixteen_bit_immediate = instr_word_in[`IAD_IMM_MSB:`IAD_IMM_LSB];  // see RULE_09
   assign source_reg_a = instr_word_in[`IAD_FA_MSB:`IAD_FA_LSB];  // see RULE_09
   assign source_reg_b = instr_word_in[`IAD_FB_MSB:`IAD_FB_LSB];
   assign dest_reg_c = instr_word_in[`IAD_FC_MSB:`IAD_FC_LSB];  // see RULE_02

   // ***************************************************************
   // decode
   // ***************************************************************
   logic is_add;     // register add selected
   logic is_addi;    // immediate add selected
   logic fault_any;  // some fetch fault present

   // r-type add needs both opcode fields
   assign is_add = instr_valid_in && primary_opcode_field == `IAD_OP_RTYPE
                   && extended_opcode_field == `IAD_OPX_ADD;  // see RULE_02
   // i-type add needs only the primary field
   assign is_addi = instr_valid_in && primary_opcode_field == `IAD_OP_ADDI;  // see RULE_09
   assign fault_any = fetch_super_only_in | fetch_fast_miss_in | fetch_double_miss_in
                      | fetch_exec_viol_in | fetch_region_viol_in;

   // ***************************************************************
   // fetch exception cause
   // ***************************************************************
   iad_cause_type cause_nxt;  // highest priority fault

   // fixed priority among simultaneous faults
   always_comb
   begin
      if (fetch_super_only_in)
         cause_nxt = IAD_CAUSE_SUPER_ONLY;  // see RULE_06
      else if (fetch_fast_miss_in)
         cause_nxt = IAD_CAUSE_FAST_MISS;
      else if (fetch_double_miss_in)
         cause_nxt = IAD_CAUSE_DOUBLE_MISS;
      else if (fetch_exec_viol_in)
         cause_nxt = IAD_CAUSE_EXEC_VIOL;
      else if (fetch_region_viol_in)
         cause_nxt = IAD_CAUSE_REGION_VIOL;
      else
         cause_nxt = IAD_CAUSE_NONE;
   end

   // ***************************************************************
   // register file read side
   // ***************************************************************
   // reads go to the current set unless the prefix marks them
   assign rf_rd_a_idx_out = source_reg_a;
   assign rf_rd_b_idx_out = source_reg_b;
   assign rf_rd_a_set_out = prev_a_sel_in ? prev_set_in : cur_set_in;  // see RULE_05
   assign rf_rd_b_set_out = prev_b_sel_in ? prev_set_in : cur_set_in;  // see RULE_05

   // ***************************************************************
   // adder
   // ***************************************************************
   iad_add_if add_bus ();  // operands to the adder

   // second addend is the register or the widened immediate
   assign add_bus.op_a = rf_rd_a_data_in;
   assign add_bus.op_b = is_addi ? iad_sext16(sixteen_bit_immediate)  // see RULE_03
                                 : rf_rd_b_data_in;  // see RULE_04

   iad_adder u_adder
   (
      .add_port(add_bus)
   );

   // ***************************************************************
   // write-back registers
   // ***************************************************************
   logic wr_en_r;            // write strobe
   iad_idx_type wr_idx_r;    // destination index
   iad_set_type wr_set_r;    // destination set
   iad_word_type wr_data_r;  // destination value
   logic other_op_r;         // valid word that is no add

   // write strobe: an add without a fetch fault
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
         wr_en_r <= 1'b0;
      else
         wr_en_r <= (is_add || is_addi) && !fault_any;  // see RULE_06
   end

   // destination index, set and value
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         wr_idx_r <= 5'h00;
         wr_set_r <= `IAD_SET_RESET;
         wr_data_r <= 32'h0000_0000;
      end
      else if (is_add || is_addi)
      begin
         // register add writes C, immediate add writes B
         wr_idx_r <= is_add ? dest_reg_c : source_reg_b;  // see RULE_01
         // results always land in the current set
         wr_set_r <= cur_set_in;  // see RULE_05
         wr_data_r <= add_bus.sum;  // see RULE_03
      end
   end

   // flag words for other execution units
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
         other_op_r <= 1'b0;
      else
         other_op_r <= instr_valid_in && !is_add && !is_addi && !fault_any;
   end

   // ***************************************************************
   // fetch exception report
   // ***************************************************************
   iad_word_type pc_r;        // address of word now offered
   logic exc_valid_r;         // exception pulse
   iad_cause_type exc_cause_r;  // reported cause
   iad_word_type exc_pc_r;    // address of faulting word

   // any fetched word may fault, whatever its opcode
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         exc_valid_r <= 1'b0;
         exc_cause_r <= IAD_CAUSE_NONE;
         exc_pc_r <= `IAD_PC_RESET;
      end
      else
      begin
         exc_valid_r <= instr_valid_in && fault_any;  // see RULE_06
         if (instr_valid_in && fault_any)
         begin
            exc_cause_r <= cause_nxt;  // see RULE_06
            exc_pc_r <= pc_r;  // see RULE_07
         end
      end
   end

   // ***************************************************************
   // program counter
   // ***************************************************************
   // a load redirects fetch; a retired word steps on
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
         pc_r <= `IAD_PC_RESET;
      else if (pc_load_in)
         pc_r <= pc_load_addr_in;  // see RULE_07
      else if (instr_valid_in && !fault_any)
         pc_r <= pc_r + `IAD_PC_STEP;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign rf_wr_en_out = wr_en_r;
   assign rf_wr_idx_out = wr_idx_r;
   assign rf_wr_set_out = wr_set_r;
   assign rf_wr_data_out = wr_data_r;
   assign other_op_out = other_op_r;
   assign exc_valid_out = exc_valid_r;
   assign exc_cause_out = exc_cause_r;
   assign exc_pc_out = exc_pc_r;
   assign fetch_pc_out = pc_r;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking chk_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // an add issued clean, then its write one cycle on
   sequence add_issue_s;
      is_add && !fault_any;
   endsequence
   sequence addi_issue_s;
      is_addi && !fault_any;
   endsequence

   reg_sum_a: assert property (add_issue_s |=> rf_wr_en_out  // see RULE_01
      && rf_wr_data_out == 32'($past(rf_rd_a_data_in) + $past(rf_rd_b_data_in))
      && rf_wr_idx_out == $past(instr_word_in[21:17]))
      else $error("register add wrote wrong value or index");
   imm_sum_a: assert property (addi_issue_s |=> rf_wr_en_out  // see RULE_03
      && rf_wr_data_out == 32'($past(rf_rd_a_data_in)
         + {{16{$past(instr_word_in[21])}}, $past(instr_word_in[21:6])})
      && rf_wr_idx_out == $past(instr_word_in[26:22]))
      else $error("immediate add wrote wrong value or index");
   opx_match_a: assert property (instr_valid_in && instr_word_in[5:0] == 6'h3a  // see RULE_02
      && instr_word_in[16:11] != 6'h31 && instr_word_in[5:0] != 6'h04 |=> !rf_wr_en_out)
      else $error("r-type word other than add was written");
   wr_set_a: assert property (rf_wr_en_out |-> rf_wr_set_out == $past(cur_set_in))  // see RULE_05
      else $error("write went to a set other than current");
   rd_set_a: assert property (!prev_a_sel_in |-> rf_rd_a_set_out == cur_set_in)  // see RULE_05
      else $error("unprefixed read left the current set");
   fault_block_a: assert property (instr_valid_in && fault_any  // see RULE_06
      |=> exc_valid_out && !rf_wr_en_out && exc_pc_out == $past(fetch_pc_out))
      else $error("fetch fault not reported or write not blocked");
   cause_first_a: assert property (instr_valid_in && fetch_super_only_in  // see RULE_06
      |=> exc_cause_out == IAD_CAUSE_SUPER_ONLY)
      else $error("supervisor-only cause lost priority");
   pc_load_a: assert property (pc_load_in  // see RULE_07
      |=> fetch_pc_out == $past(pc_load_addr_in))
      else $error("loaded address is not the next fetch");
   pc_step_a: assert property (!pc_load_in && instr_valid_in && !fault_any  // see RULE_07
      |=> fetch_pc_out == 32'($past(fetch_pc_out) + 32'h0000_0004))
      else $error("pc did not step by one word");
   // carry is dropped and no exception is raised for it
   wrap_sum_a: assert property (add_issue_s  // see RULE_10
      |=> rf_wr_data_out == 32'($past({1'b0, rf_rd_a_data_in} + {1'b0, rf_rd_b_data_in}))
      && !exc_valid_out)
      else $error("sum not wrapped to 32 bits or overflow raised");

endmodule : iad_datapath

// ### rtl/iad_pkg.sv
// types shared by the integer add datapath
package iad_pkg;

   // ***************************************************************
   // data types
   // ***************************************************************
   typedef logic [31:0] iad_word_type;   // general-purpose register width
   typedef logic [4:0] iad_idx_type;     // register index
   typedef logic [5:0] iad_set_type;     // register set number

   // fetch exception causes, in priority order
   typedef enum logic [2:0]
   {
      IAD_CAUSE_NONE = 3'h0,
      IAD_CAUSE_SUPER_ONLY = 3'h1,
      IAD_CAUSE_FAST_MISS = 3'h2,
      IAD_CAUSE_DOUBLE_MISS = 3'h3,
      IAD_CAUSE_EXEC_VIOL = 3'h4,
      IAD_CAUSE_REGION_VIOL = 3'h5
   } iad_cause_type;

   // sign-extend a 16-bit immediate to full register width
   function automatic iad_word_type iad_sext16(input logic [15:0] imm);
      return {{16{imm[15]}}, imm};
   endfunction : iad_sext16

endpackage : iad_pkg

// ### rtl/iad_regs.svh
// field positions, opcodes and reset values of the integer add datapath
//
// How it works
// RULE_01: register add writes dest with the sum
// RULE_02: register add is opcode 0x3a, extended 0x31
// RULE_03: immediate add sign-extends immediate, writes B
// RULE_04: operands and results are 32 bits wide
// RULE_05: accesses use current set unless prefixed
// RULE_06: fetch faults raise the five fetch exceptions
// RULE_07: pc is own address; loads redirect fetch
// RULE_08: bit zero is least significant bit
// RULE_09: immediate add is opcode 0x04, I-type layout
// RULE_10: keep low 32 sum bits, no overflow
`ifndef IAD_REGS_SVH
`define IAD_REGS_SVH

// ***************************************************************
// instruction word fields, bit zero is the lsb
// ***************************************************************
`define IAD_WORD_W 32
`define IAD_OP_LSB 0
`define IAD_OP_MSB 5
`define IAD_IMM_LSB 6
`define IAD_IMM_MSB 21
`define IAD_OPX_LSB 11
`define IAD_OPX_MSB 16
`define IAD_FC_LSB 17
`define IAD_FC_MSB 21
`define IAD_FB_LSB 22
`define IAD_FB_MSB 26
`define IAD_FA_LSB 27
`define IAD_FA_MSB 31

// ***************************************************************
// opcode values
// ***************************************************************
`define IAD_OP_RTYPE 6'h3a
`define IAD_OPX_ADD 6'h31
`define IAD_OP_ADDI 6'h04

// ***************************************************************
// program counter and register set reset
// ***************************************************************
`define IAD_PC_STEP 32'h0000_0004
`define IAD_PC_RESET 32'h0000_0000
`define IAD_SET_RESET 6'h00

`endif
